// file: rtl/sysctl_pkg.sv
package sysctl_pkg;
	// register byte offsets on the bus
	localparam logic [11:0] OFF_CFG_A     = 12'h000;
	localparam logic [11:0] OFF_CFG_B     = 12'h004;
	localparam logic [11:0] OFF_CFG_C     = 12'h008;
	localparam logic [11:0] OFF_PRI_SPI   = 12'h00c;
	localparam logic [11:0] OFF_PRI_SCI   = 12'h010;
	localparam logic [11:0] OFF_PRI_T1    = 12'h014;
	localparam logic [11:0] OFF_PRI_T2A   = 12'h018;
	localparam logic [11:0] OFF_PRI_ADC   = 12'h01c;
	localparam logic [11:0] OFF_STATUS    = 12'h020;
	localparam logic [11:0] OFF_VECTOR    = 12'h024;
	localparam logic [11:0] OFF_WAIT_CMD  = 12'h028;

	// protected-bit masks per register
	localparam logic [7:0] PROT_CFG_A = 8'h60;
	localparam logic [7:0] PROT_CFG_B = 8'h14;
	localparam logic [7:0] PROT_CFG_C = 8'hdb;
	localparam logic [7:0] PROT_SPI   = 8'he0;
	localparam logic [7:0] PROT_SCI   = 8'hf0;
	localparam logic [7:0] PROT_T1    = 8'hc0;
	localparam logic [7:0] PROT_T2A   = 8'hc0;
	localparam logic [7:0] PROT_ADC   = 8'he0;
	localparam logic [7:0] RESET_BYTE = 8'h00;

	// config c field positions
	localparam int CFG_LOCK_BIT   = 0;
	localparam int CFG_NMI_BIT    = 1;
	localparam int CFG_LPEN_BIT   = 6;
	localparam int CFG_DEPTH_BIT  = 7;

	localparam int NUM_IRQ = 10;
	localparam logic [15:0] VEC_BASE = 16'h7fec;
	localparam logic [15:0] VEC_NONE = 16'h0000;

	typedef enum logic [1:0] {
		PM_RUN   = 2'b00,
		PM_IDLE  = 2'b01,
		PM_LIGHT = 2'b10,
		PM_DEEP  = 2'b11
	} power_state_t;
endpackage

// file: rtl/sysctl_bus_if.sv
`timescale 1ns/100ps
`default_nettype none
interface sysctl_bus_if;
	logic        wr;
	logic [11:0] addr;
	logic [7:0]  wdata;
	logic        lock;
	modport ctrl (output wr, output addr, output wdata, input lock);
	modport regs (input wr, input addr, input wdata, output lock);
endinterface
`default_nettype wire

// file: rtl/sysctl_priority.sv
`timescale 1ns/100ps
`default_nettype none
module sysctl_priority
	import sysctl_pkg::*;
(
	// clock and reset
	input  wire logic                 clk,
	input  wire logic                 arst_n,
	// pending lines, bit 0 is reset group
	input  wire logic [NUM_IRQ-1:0]   pending,
	// winner
	output logic                      any,
	output logic [15:0]               vector
);
	import sysctl_pkg::*;

	logic [15:0] next_vector;
	logic        next_any;

	// lowest index wins: priority 1 at bit 0
	always_comb begin
		next_vector = VEC_NONE;
		next_any    = 1'b0;
		for (int i = NUM_IRQ - 1; i >= 0; i--) begin
			if (pending[i]) begin
				next_any    = 1'b1;
				next_vector = VEC_BASE + 16'((NUM_IRQ - 1 - i) * 2);
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			any    <= 1'b0;
			vector <= VEC_NONE;
		end else begin
			any    <= next_any;
			vector <= next_vector;
		end
	end
endmodule
`default_nettype wire

// file: rtl/sysctl_top.sv
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - reset, ext a/b/c, spi vectors ranked
// - timer one sources share vector 7ff4
// - receive full or break raises receive irq
// - transmit empty raises transmit irq
// - timer 2a and converter at lowest ranks
// - reset starts privileged, all bits writable
// - lock bit set enters nonprivileged mode
// - system config protected bits blocked when locked
// - peripheral priority/suspend/test bits blocked when locked
// - high voltage after reset enters override
// - wait with enable enters low power
// - light sleep keeps oscillator and timer one
// - light sleep wakes on listed sources
// - reset, ext, receive wake both depths
// - timer one wakes light sleep only
// - build option disables low power
// - deep sleep stops clocks; else idle
// - disabled option ignores selects, always idle
// - hard watchdog forces ext a nonmaskable in light or deep sleep
module sysctl_top
	import sysctl_pkg::*;
#(
	parameter bit LOWPOWER_DISABLED = 1'b0
) (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        arst_n,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic             pslverr,
	output logic [31:0]      prdata,
	// pins
	input  wire logic        mode_control_pin_hv,
	input  wire logic        ext_irq_a,
	input  wire logic        ext_irq_b,
	input  wire logic        ext_irq_c,
	input  wire logic        serial_rx_pin,
	input  wire logic        hard_watchdog_mode,
	// peripheral flags
	input  wire logic        reset_group_irq,
	input  wire logic        serial_periph_irq,
	input  wire logic [5:0]  timer_one_sources,
	input  wire logic        receive_full_flag,
	input  wire logic        break_detect_flag,
	input  wire logic        transmit_empty_flag,
	input  wire logic [5:0]  timer_twoa_sources,
	input  wire logic        converter_done_irq,
	// cpu side
	input  wire logic        wait_instr,
	output logic             irq_any,
	output logic [15:0]      irq_vector,
	output logic             ext_irq_a_nonmaskable,
	output logic             eeprom_protect_override,
	output logic             cpu_halted,
	output logic             periph_clk_en,
	output logic             timer_one_clk_en,
	output logic             osc_run
);
	import sysctl_pkg::*;

	sysctl_bus_if bus ();

	power_state_t pstate;
	logic [7:0] cfg_a, cfg_b, cfg_c, pri_spi, pri_sci, pri_t1, pri_t2a, pri_adc;
	logic [1:0] ea_s, eb_s, ec_s;
	logic [1:0] rx_s, hv_s;
	logic       hv_ok;
	logic       timer_one_irq, serial_receive_irq, serial_transmit_irq, timer_twoa_irq;
	logic [NUM_IRQ-1:0] pending;
	logic       wake_any, wake_deep;

	// write merge that keeps protected bits when locked
	function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] nw,
			input logic [7:0] prot, input logic locked);
		merge = locked ? ((old & prot) | (nw & ~prot)) : nw;
	endfunction

	// pins except hard_watchdog_mode pass two flops before use
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ea_s <= 2'h0;
			eb_s <= 2'h0;
			ec_s <= 2'h0;
			rx_s <= 2'h3;
			// starts high: a level held through release must be seen low first
			hv_s <= 2'h3;
		end else begin
			ea_s <= {ea_s[0], ext_irq_a};
			eb_s <= {eb_s[0], ext_irq_b};
			ec_s <= {ec_s[0], ext_irq_c};
			rx_s <= {rx_s[0], serial_rx_pin};
			hv_s <= {hv_s[0], mode_control_pin_hv};
		end
	end

	assign timer_one_irq       = |timer_one_sources;
	assign serial_receive_irq  = receive_full_flag | break_detect_flag;
	assign serial_transmit_irq = transmit_empty_flag;
	assign timer_twoa_irq      = |timer_twoa_sources;

	assign pending = {converter_done_irq, timer_twoa_irq, serial_transmit_irq,
		serial_receive_irq, timer_one_irq, serial_periph_irq,
		ec_s[1], eb_s[1], ea_s[1], reset_group_irq};

	sysctl_priority u_prio (
		.clk     (clk),
		.arst_n  (arst_n),
		.pending (pending),
		.any     (irq_any),
		.vector  (irq_vector)
	);

	// apb front end, zero wait states
	assign pready     = 1'b1;
	assign bus.wr     = psel && penable && pwrite;
	assign bus.addr   = paddr;
	assign bus.wdata  = pwdata[7:0];

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pslverr <= 1'b0;
		end else begin
			pslverr <= 1'b0;
		end
	end

	// reset leaves all config cleared and unlocked
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cfg_a   <= RESET_BYTE;
			cfg_b   <= RESET_BYTE;
			cfg_c   <= RESET_BYTE;
			pri_spi <= RESET_BYTE;
			pri_sci <= RESET_BYTE;
			pri_t1  <= RESET_BYTE;
			pri_t2a <= RESET_BYTE;
			pri_adc <= RESET_BYTE;
		end else if (bus.wr) begin
			unique case (bus.addr)
				OFF_CFG_A: cfg_a <= merge(cfg_a, bus.wdata, PROT_CFG_A, bus.lock);
				OFF_CFG_B: cfg_b <= merge(cfg_b, bus.wdata, PROT_CFG_B, bus.lock);
				OFF_CFG_C: begin
					cfg_c <= merge(cfg_c, bus.wdata, PROT_CFG_C, bus.lock);
					if (bus.lock)
						cfg_c[CFG_LOCK_BIT] <= 1'b1;
					if (LOWPOWER_DISABLED) begin
						cfg_c[CFG_LPEN_BIT]  <= 1'b0;
						cfg_c[CFG_DEPTH_BIT] <= 1'b0;
					end
				end
				OFF_PRI_SPI: pri_spi <= merge(pri_spi, bus.wdata, PROT_SPI, bus.lock);
				OFF_PRI_SCI: pri_sci <= merge(pri_sci, bus.wdata, PROT_SCI, bus.lock);
				OFF_PRI_T1:  pri_t1  <= merge(pri_t1, bus.wdata, PROT_T1, bus.lock);
				OFF_PRI_T2A: pri_t2a <= merge(pri_t2a, bus.wdata, PROT_T2A, bus.lock);
				OFF_PRI_ADC: pri_adc <= merge(pri_adc, bus.wdata, PROT_ADC, bus.lock);
				default: ;
			endcase
		end
	end

	assign bus.lock = cfg_c[CFG_LOCK_BIT];

	// read mux from flops
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			prdata <= 32'h0;
		end else if (psel && !penable && !pwrite) begin
			unique case (paddr)
				OFF_CFG_A:   prdata <= {24'h0, cfg_a};
				OFF_CFG_B:   prdata <= {24'h0, cfg_b};
				OFF_CFG_C:   prdata <= {24'h0, cfg_c};
				OFF_PRI_SPI: prdata <= {24'h0, pri_spi};
				OFF_PRI_SCI: prdata <= {24'h0, pri_sci};
				OFF_PRI_T1:  prdata <= {24'h0, pri_t1};
				OFF_PRI_T2A: prdata <= {24'h0, pri_t2a};
				OFF_PRI_ADC: prdata <= {24'h0, pri_adc};
				OFF_STATUS:  prdata <= {26'h0, pstate, eeprom_protect_override,
					bus.lock, irq_any, 1'b0};
				OFF_VECTOR:  prdata <= {16'h0, irq_vector};
				default:     prdata <= 32'h0;
			endcase
		end
	end

	// override only after reset release; drops with voltage
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			hv_ok                   <= 1'b0;
			eeprom_protect_override <= 1'b0;
		end else begin
			// level present through release is not accepted until it drops once
			if (!hv_s[1])
				hv_ok <= 1'b1;
			eeprom_protect_override <= hv_ok && hv_s[1];
		end
	end

	// reset, ext, receive-pin-low wake any depth
	assign wake_deep = reset_group_irq | ea_s[1] | eb_s[1] | ec_s[1] | !rx_s[1]
		| serial_receive_irq;
	// light sleep also wakes on timer one; deep does not
	assign wake_any  = wake_deep | timer_one_irq;

	// wait instruction enters low power; option; idle otherwise
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pstate <= PM_RUN;
		end else begin
			unique case (pstate)
				PM_RUN: begin
					if (wait_instr) begin
						if (LOWPOWER_DISABLED || !cfg_c[CFG_LPEN_BIT])
							pstate <= PM_IDLE;
						else if (cfg_c[CFG_DEPTH_BIT])
							pstate <= PM_DEEP;
						else
							pstate <= PM_LIGHT;
					end
				end
				PM_IDLE:  if (irq_any) pstate <= PM_RUN;
				PM_LIGHT: if (wake_any) pstate <= PM_RUN;
				PM_DEEP:  if (wake_deep) pstate <= PM_RUN;
			endcase
		end
	end

	// light keeps oscillator and timer one; deep stops all
	assign cpu_halted       = (pstate != PM_RUN);
	assign periph_clk_en    = (pstate == PM_RUN) || (pstate == PM_IDLE);
	assign timer_one_clk_en = (pstate != PM_DEEP);
	assign osc_run          = (pstate != PM_DEEP);

	// hard watchdog forces nonmaskable in low power
	assign ext_irq_a_nonmaskable = cfg_c[CFG_NMI_BIT]
		|| (hard_watchdog_mode && (pstate == PM_LIGHT || pstate == PM_DEEP));
endmodule
`default_nettype wire

// file: testbench/sysctl_checker.sv
`timescale 1ns/100ps
`default_nettype none
module sysctl_checker
	import sysctl_pkg::*;
(
	// clock and reset
	input wire logic        clk, arst_n,
	// pins and flags
	input wire logic        ext_irq_b, mode_control_pin_hv, hard_watchdog_mode,
	input wire logic        reset_group_irq, serial_periph_irq, receive_full_flag,
	input wire logic        break_detect_flag, transmit_empty_flag, wait_instr,
	input wire logic [5:0]  timer_one_sources, timer_twoa_sources,
	// outputs
	input wire logic        irq_any, ext_irq_a_nonmaskable, eeprom_protect_override,
	input wire logic        cpu_halted, periph_clk_en, timer_one_clk_en, osc_run,
	input wire logic [15:0] irq_vector
);
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	// a higher vector means a higher rank, so pending lines bound it from below
	rst_vec_a: assert property (reset_group_irq |=> irq_vector == 16'h7ffe)
		else $error("reset vector wrong");
	spi_vec_a: assert property (serial_periph_irq |=> irq_vector >= 16'h7ff6)
		else $error("spi vector lost");
	t1_vec_a: assert property (|timer_one_sources |=> irq_vector >= 16'h7ff4)
		else $error("timer one vector lost");
	rx_vec_a: assert property (receive_full_flag || break_detect_flag
			|=> irq_vector >= 16'h7ff2)
		else $error("receive vector lost");
	tx_vec_a: assert property (transmit_empty_flag |=> irq_vector >= 16'h7ff0)
		else $error("transmit vector lost");
	t2a_vec_a: assert property (|timer_twoa_sources |=> irq_vector >= 16'h7fee)
		else $error("timer 2a vector lost");
	no_irq_a: assert property (!irq_any |-> irq_vector == 16'h0000)
		else $error("vector without request");
	deep_stop_a: assert property (!osc_run
			|-> cpu_halted && !timer_one_clk_en && !periph_clk_en)
		else $error("clock alive in deep sleep");
	light_run_a: assert property (cpu_halted && osc_run |-> timer_one_clk_en)
		else $error("timer one stopped");
	deep_wake_a: assert property (!osc_run && ext_irq_b |-> ##[1:6] osc_run)
		else $error("no wake from deep sleep");
	wd_nmi_a: assert property (hard_watchdog_mode && !osc_run |-> ext_irq_a_nonmaskable)
		else $error("ext a not forced nonmaskable");
	hv_off_a: assert property (!mode_control_pin_hv [*5] |-> !eeprom_protect_override)
		else $error("override without high voltage");
	wait_halt_a: assert property (wait_instr && !irq_any && !cpu_halted |=> cpu_halted)
		else $error("wait did not halt");
endmodule
bind sysctl_top sysctl_checker u_chk (.*);
`default_nettype wire

// file: testbench/periph_model.sv
`timescale 1ns/100ps
`default_nettype none
module periph_model (
	// clock, reset, selection
	input  wire logic        clk, arst_n,
	input  wire logic [10:0] mask,
	input  wire logic [5:0]  pat,
	// flag lines
	output logic             reset_group_irq, ext_irq_a, ext_irq_b, ext_irq_c,
	output logic             serial_periph_irq, receive_full_flag, break_detect_flag,
	output logic             transmit_empty_flag, converter_done_irq,
	output logic [5:0]       timer_one_sources, timer_twoa_sources
);
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			{converter_done_irq, transmit_empty_flag, break_detect_flag, receive_full_flag,
			 serial_periph_irq, ext_irq_c, ext_irq_b, ext_irq_a, reset_group_irq} <= 9'h000;
			timer_one_sources <= 6'h00;
			timer_twoa_sources <= 6'h00;
		end else begin
			{converter_done_irq, transmit_empty_flag, break_detect_flag, receive_full_flag,
			 serial_periph_irq, ext_irq_c, ext_irq_b, ext_irq_a, reset_group_irq}
				<= {mask[10], mask[8:6], mask[4:0]};
			timer_one_sources <= mask[5] ? pat : 6'h00;
			timer_twoa_sources <= mask[9] ? pat : 6'h00;
		end
	end
endmodule
`default_nettype wire

// file: testbench/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	import sysctl_pkg::*;
	logic clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic mode_control_pin_hv = 1'b0, serial_rx_pin = 1'b1, hard_watchdog_mode = 1'b0;
	logic wait_instr = 1'b0, rd_valid = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd_data, lfsr = 32'h0001612a;
	logic [31:0] lp_prdata, rd_lp;
	logic lp_halted, lp_osc_run;
	logic pready, pslverr, irq_any, ext_irq_a_nonmaskable, eeprom_protect_override;
	logic cpu_halted, periph_clk_en, timer_one_clk_en, osc_run;
	logic reset_group_irq, ext_irq_a, ext_irq_b, ext_irq_c, serial_periph_irq;
	logic receive_full_flag, break_detect_flag, transmit_empty_flag, converter_done_irq;
	logic [5:0] timer_one_sources, timer_twoa_sources, pat = 6'h01;
	logic [7:0] lvl;
	logic [10:0] mask = 11'h000;
	logic [15:0] irq_vector;
	logic [31:0] exp_q[$];
	int err_count = 0, compares = 0;
	localparam logic [11:0] ADR [7] = '{OFF_CFG_A, OFF_CFG_B, OFF_PRI_SPI, OFF_PRI_SCI,
		OFF_PRI_T1, OFF_PRI_T2A, OFF_PRI_ADC};
	localparam logic [7:0] MSK [7] = '{PROT_CFG_A, PROT_CFG_B, PROT_SPI, PROT_SCI,
		PROT_T1, PROT_T2A, PROT_ADC};
	assign lvl = {lp_halted, lp_osc_run, ext_irq_a_nonmaskable, eeprom_protect_override,
		periph_clk_en, timer_one_clk_en, osc_run, cpu_halted};
	sysctl_top u_dut (.*);
	// build option set: every wait must collapse into idle
	sysctl_top #(
		.LOWPOWER_DISABLED (1'b1)
	) u_dut_lp (
		.*,
		.pready                  (),
		.pslverr                 (),
		.prdata                  (lp_prdata),
		.irq_any                 (),
		.irq_vector              (),
		.ext_irq_a_nonmaskable   (),
		.eeprom_protect_override (),
		.cpu_halted              (lp_halted),
		.periph_clk_en           (),
		.timer_one_clk_en        (),
		.osc_run                 (lp_osc_run)
	);
	periph_model u_periph (.*);
	always #50 clk = ~clk;
	function automatic logic [31:0] rnd();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr;
	endfunction
	task automatic end_sim();
		if (err_count == 0 && compares > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clk);
	endtask
	// upper write bits are random: only the low byte may matter
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		logic [31:0] r;
		r = rnd();
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {r[31:8], d};
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		rd_valid <= !w;
		rd_data <= prdata;
		rd_lp <= lp_prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
		rd_valid <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		apb(1'b0, a, 8'h00);
	endtask
	// levels are sampled mid-cycle, away from the launching edge
	task automatic look(input int s, input logic [15:0] e);
		logic [15:0] g;
		@(negedge clk);
		g = (s == 0) ? irq_vector : {15'h0, lvl[s-1]};
		cmp({16'h0, g}, {16'h0, e});
		@(posedge clk);
	endtask
	task automatic sleep(input logic [7:0] cfg);
		apb(1'b1, OFF_CFG_C, cfg);
		wait_instr <= 1'b1;
		@(posedge clk);
		wait_instr <= 1'b0;
	endtask
	always @(posedge clk) if (rd_valid) cmp(rd_data, exp_q.pop_front());
	initial begin
		#400000;
		err_count++;
		end_sim();
	end
	initial begin
		logic [31:0] r;
		logic [7:0] v [7];
		step(16);
		arst_n <= 1'b1;
		step(1);
		for (int i = 10; i >= 0; i--) begin
			r = rnd();
			pat <= 6'h01 << (r % 6);
			mask <= 11'h7ff << i;
			step(6);
			look(0, 16'h7ffe - 16'(2 * (i > 6 ? i - 1 : i)));
		end
		mask <= 11'h000;
		step(6);
		look(0, 16'h0000);
		mode_control_pin_hv <= 1'b1;
		step(5);
		look(5, 16'h1);
		mode_control_pin_hv <= 1'b0;
		step(5);
		look(5, 16'h0);
		sleep(8'h40);
		look(1, 16'h1);
		look(3, 16'h1);
		look(4, 16'h0);
		mask <= 11'h020;
		step(3);
		look(1, 16'h0);
		mask <= 11'h000;
		hard_watchdog_mode <= 1'b1;
		step(4);
		sleep(8'hc0);
		look(2, 16'h0);
		look(6, 16'h1);
		look(7, 16'h1);
		look(8, 16'h1);
		rd(OFF_CFG_C, 32'hc0);
		cmp(rd_lp, 32'h0);
		mask <= 11'h020;
		step(4);
		look(1, 16'h1);
		mask <= 11'h004;
		step(6);
		look(1, 16'h0);
		mask <= 11'h000;
		hard_watchdog_mode <= 1'b0;
		step(5);
		sleep(8'hc0);
		serial_rx_pin <= 1'b0;
		step(6);
		look(1, 16'h0);
		serial_rx_pin <= 1'b1;
		step(5);
		sleep(8'h00);
		look(2, 16'h1);
		mask <= 11'h400;
		step(3);
		look(1, 16'h0);
		mask <= 11'h000;
		step(3);
		for (int k = 0; k < 7; k++) begin
			r = rnd();
			v[k] = r[7:0];
			apb(1'b1, ADR[k], v[k]);
			rd(ADR[k], {24'h0, v[k]});
		end
		apb(1'b1, OFF_CFG_C, 8'h01);
		rd(OFF_STATUS, 32'h4);
		for (int k = 0; k < 7; k++) begin
			r = rnd();
			apb(1'b1, ADR[k], r[7:0]);
			rd(ADR[k], {24'h0, (v[k] & MSK[k]) | (r[7:0] & ~MSK[k])});
		end
		apb(1'b1, OFF_CFG_C, 8'h24);
		rd(OFF_CFG_C, 32'h25);
		rd(12'h0fc, 32'h0);
		// second reset with the high level already on the pin
		mode_control_pin_hv <= 1'b1;
		arst_n <= 1'b0;
		step(2);
		arst_n <= 1'b1;
		step(6);
		look(5, 16'h0);
		rd(OFF_CFG_C, 32'h0);
		mode_control_pin_hv <= 1'b0;
		step(5);
		mode_control_pin_hv <= 1'b1;
		step(5);
		look(5, 16'h1);
		step(3);
		end_sim();
	end
endmodule
`default_nettype wire
